// File: rtl/dram_ctl.sv
// Host-side controller driving a 256K x 1 dynamic RAM through its strobes
// Function
// - No refresh by access on shared bus
// - Strobe-only refresh all 256 rows per 4ms
// - Column strobe falls before row, held after
// - Wait 500us then eight dummy cycles
// - Address as row then column halves
`timescale 1ns/1ps
`default_nettype none
module dram_ctl
    import dram_ctl_pkg::*;
#(
    parameter int unsigned PWRUP     = PWRUP_CYC,
    parameter int unsigned REF_INT   = REF_INT_CYC,
    parameter ref_mode_e   REF_MODE  = REF_RAS_ONLY
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic        i_req_valid,
    input  wire logic        i_req_write,
    input  wire logic [17:0] i_req_addr,
    input  wire logic        i_req_wdata,
    output logic             o_req_ready,
    output logic             o_rsp_valid,
    output logic             o_rsp_rdata,
    output logic             o_init_done,
    output logic             o_ras_n,
    output logic             o_cas_n,
    output logic             o_we_n,
    output logic [8:0]       o_addr,
    output logic             o_din,
    input  wire logic        i_dout
);
    typedef enum logic [3:0] {
        ST_PWRUP, ST_IDLE, ST_ROW, ST_COL, ST_PRE, ST_CBR_CAS, ST_CBR_RAS
    } state_e;

    state_e      state_reg;
    logic [15:0] tim_reg;
    logic [3:0]  dummy_reg;
    logic        init_reg;
    logic        is_ref_reg;
    logic        wr_reg;
    logic [8:0]  col_reg;
    logic        dq_s1_reg;
    logic        dq_s2_reg;
    logic        ref_due;
    logic        ref_done;
    logic [7:0]  ref_row;
    logic        tim_zero;

    assign tim_zero = (tim_reg == 16'h0000);

    dram_ref_timer #(
        .INTERVAL (REF_INT)
    ) u_timer (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_ce   (i_ce),
        .i_done (ref_done),
        .o_due  (ref_due),
        .o_row  (ref_row)
    );

    // Pin input synchroniser
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dq_s1_reg <= 1'b0;
            dq_s2_reg <= 1'b0;
        end else if (i_ce) begin
            dq_s1_reg <= i_dout;
            dq_s2_reg <= dq_s1_reg;
        end
    end

    assign o_req_ready = i_ce && init_reg && state_reg == ST_IDLE && !ref_due;
    assign ref_done = i_ce && is_ref_reg && state_reg == ST_PRE && tim_zero;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg  <= ST_PWRUP;
            tim_reg    <= 16'(PWRUP);
            dummy_reg  <= 4'h0;
            init_reg   <= 1'b0;
            is_ref_reg <= 1'b0;
            wr_reg     <= 1'b0;
            col_reg    <= 9'h000;
            o_ras_n    <= 1'b1;
            o_cas_n    <= 1'b1;
            o_we_n     <= 1'b1;
            o_addr     <= 9'h000;
            o_din      <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rsp_rdata <= 1'b0;
        end else if (i_ce) begin
            o_rsp_valid <= 1'b0;
            if (!tim_zero) begin
                tim_reg <= tim_reg - 16'h0001;
            end
            unique case (state_reg)
                ST_PWRUP: begin
                    if (tim_zero) begin
                        // Dummy strobe-only cycles after the pause
                        state_reg  <= ST_ROW;
                        is_ref_reg <= 1'b0;
                        o_ras_n    <= 1'b0;
                        tim_reg    <= 16'(RAS_LOW_CYC - 1);
                    end
                end
                ST_IDLE: begin
                    if (ref_due && REF_MODE == REF_CBR) begin
                        o_cas_n    <= 1'b0;
                        is_ref_reg <= 1'b1;
                        state_reg  <= ST_CBR_CAS;
                        tim_reg    <= 16'(CSR_CYC - 1);
                    end else if (ref_due) begin
                        // Column strobe stays high, counter row on the bus
                        // Refresh never rides on a normal access
                        o_addr     <= {1'b0, ref_row};
                        is_ref_reg <= 1'b1;
                        state_reg  <= ST_ROW;
                        tim_reg    <= 16'(ASR_CYC - 1);
                    end else if (i_req_valid && o_req_ready) begin
                        // Row half first, column half held for later
                        o_addr     <= i_req_addr[17:9];
                        col_reg    <= i_req_addr[8:0];
                        wr_reg     <= i_req_write;
                        o_din      <= i_req_wdata;
                        is_ref_reg <= 1'b0;
                        state_reg  <= ST_ROW;
                        tim_reg    <= 16'(ASR_CYC - 1);
                    end
                end
                ST_ROW: begin
                    if (o_ras_n && tim_zero) begin
                        o_ras_n <= 1'b0;
                        tim_reg <= 16'(is_ref_reg || !init_reg
                                       ? RAS_LOW_CYC - 1 : RCD_CYC - 1);
                    end else if (!o_ras_n && tim_zero) begin
                        if (is_ref_reg || !init_reg) begin
                            o_ras_n   <= 1'b1;
                            state_reg <= ST_PRE;
                            tim_reg   <= 16'(RAS_PRE_CYC - 1);
                        end else begin
                            // Early write keeps the output off
                            o_addr    <= col_reg;
                            o_we_n    <= !wr_reg;
                            o_cas_n   <= 1'b0;
                            state_reg <= ST_COL;
                            tim_reg   <= 16'(CAS_LOW_CYC - 1);
                        end
                    end
                end
                ST_COL: begin
                    if (tim_zero) begin
                        // Data sampled before the column strobe rises
                        o_rsp_valid <= 1'b1;
                        o_rsp_rdata <= wr_reg ? 1'b0 : dq_s2_reg;
                        o_ras_n     <= 1'b1;
                        // No hidden refresh: data taken before column strobe rises
                        o_cas_n     <= 1'b1;
                        o_we_n      <= 1'b1;
                        state_reg   <= ST_PRE;
                        tim_reg     <= 16'(RAS_PRE_CYC - 1);
                    end
                end
                ST_CBR_CAS: begin
                    if (tim_zero) begin
                        o_ras_n   <= 1'b0;
                        state_reg <= ST_CBR_RAS;
                        tim_reg   <= 16'(RAS_LOW_CYC - 1);
                    end
                end
                ST_CBR_RAS: begin
                    if (tim_zero) begin
                        o_ras_n   <= 1'b1;
                        o_cas_n   <= 1'b1;
                        state_reg <= ST_PRE;
                        tim_reg   <= 16'(RAS_PRE_CYC - 1);
                    end
                end
                ST_PRE: begin
                    if (tim_zero) begin
                        is_ref_reg <= 1'b0;
                        if (!init_reg && dummy_reg != 4'(INIT_CYCLES - 1)) begin
                            dummy_reg <= dummy_reg + 4'h1;
                            o_ras_n   <= 1'b0;
                            state_reg <= ST_ROW;
                            tim_reg   <= 16'(RAS_LOW_CYC - 1);
                        end else begin
                            init_reg  <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign o_init_done = init_reg;

    // Row strobe held low no longer than allowed
    chk_ras_low_bound: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_ras_n) && i_ce |-> ##[1:300] o_ras_n)
        else $error("row strobe stuck low");
    chk_cbr_order: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_ras_n) && !o_cas_n && $past(!o_cas_n) |-> state_reg == ST_CBR_RAS)
        else $error("column-first refresh order broken");
    chk_refonly_cas: assert property (@(posedge i_clk) disable iff (i_rst)
        state_reg == ST_ROW && is_ref_reg |-> o_cas_n)
        else $error("column strobe low in strobe-only refresh");
    chk_no_req_init: assert property (@(posedge i_clk) disable iff (i_rst)
        !init_reg |-> !o_req_ready)
        else $error("request accepted before init");
    chk_col_after_row: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_cas_n) && state_reg == ST_COL |-> !o_ras_n)
        else $error("column strobe before row in access");
    chk_cbr_setup: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_ras_n) && !o_cas_n |-> !$past(o_cas_n, CSR_CYC))
        else $error("column strobe setup before row strobe too short");
    chk_ras_pre_min: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_ras_n) |-> o_ras_n [*5])
        else $error("row strobe precharge too short");
endmodule
`default_nettype wire

// File: rtl/dram_ctl_pkg.sv
// Constants for the host-side controller of the 256K x 1 dynamic RAM
`default_nettype none
package dram_ctl_pkg;
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned CLK_NS         = 25;
    localparam int unsigned ROW_ADDR_W     = 9;
    localparam int unsigned REF_ROWS       = 256;
    localparam int unsigned REF_PERIOD_US  = 4000;
    localparam int unsigned PWRUP_WAIT_US  = 500;
    localparam int unsigned INIT_CYCLES    = 8;
    localparam int unsigned RAS_PRE_NS     = 120;
    localparam int unsigned RAS_LOW_NS     = 200;
    localparam int unsigned RCD_NS         = 30;
    localparam int unsigned CAS_LOW_NS     = 100;
    localparam int unsigned CSR_NS         = 40;
    localparam int unsigned CHR_NS         = 50;
    localparam int unsigned ASR_NS         = 25;
    // Least times round up, longest round down
    localparam int unsigned RAS_PRE_CYC = (RAS_PRE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RAS_LOW_CYC = (RAS_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RCD_CYC     = (RCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CAS_LOW_CYC = (CAS_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CSR_CYC     = (CSR_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CHR_CYC     = (CHR_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ASR_CYC     = (ASR_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned PWRUP_CYC   = PWRUP_WAIT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned REF_INT_CYC =
        REF_PERIOD_US * (CLK_HZ / 1_000_000) / REF_ROWS;
    typedef enum logic [1:0] {
        REF_RAS_ONLY,
        REF_CBR
    } ref_mode_e;
endpackage
`default_nettype wire

// File: rtl/dram_ref_timer.sv
// Refresh interval timer and external refresh row counter
`timescale 1ns/1ps
`default_nettype none
module dram_ref_timer
    import dram_ctl_pkg::*;
#(
    parameter int unsigned INTERVAL = REF_INT_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic       i_done,
    output logic            o_due,
    output logic [7:0]      o_row
);
    logic [15:0] cnt_reg;
    logic        due_reg;
    logic [7:0]  row_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg <= 16'h0000;
        end else if (i_ce) begin
            if (cnt_reg == 16'(INTERVAL - 1)) begin
                cnt_reg <= 16'h0000;
            end else begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    // A tick that meets a completion keeps the request pending
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            due_reg <= 1'b0;
        end else if (i_ce) begin
            if (cnt_reg == 16'(INTERVAL - 1)) begin
                due_reg <= 1'b1;
            end else if (i_done) begin
                due_reg <= 1'b0;
            end
        end
    end

    // Sequential row addresses for strobe-only refresh
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            row_reg <= 8'h00;
        end else if (i_ce && i_done) begin
            row_reg <= row_reg + 8'h01;
        end
    end

    assign o_due = due_reg;
    assign o_row = row_reg;
endmodule
`default_nettype wire

// File: verif/dram_model.sv
// Behavioural 256K x 1 dynamic RAM with refresh bookkeeping
`timescale 1ns/1ps
`default_nettype none
module dram_model (
    input  wire logic        i_clk,
    input  wire logic        i_ras_n,
    input  wire logic        i_cas_n,
    input  wire logic        i_we_n,
    input  wire logic [8:0]  i_addr,
    input  wire logic        i_din,
    output logic             o_dout,
    output logic [31:0]      o_ras_falls,
    output logic [31:0]      o_ext_refs,
    output logic [31:0]      o_int_refs,
    output logic [31:0]      o_seq_errs
);
    logic       mem [0:262143];
    logic [8:0] row_reg;
    logic [8:0] col_reg;
    logic [7:0] int_row;
    logic [7:0] exp_row;
    logic       seen;
    logic       cbr_reg;
    logic       acc_reg;
    logic       junk;
    initial begin
        o_ras_falls = '0;
        o_ext_refs  = '0;
        o_int_refs  = '0;
        o_seq_errs  = '0;
        int_row     = 8'h00;
        seen        = 1'b0;
        junk        = 1'b0;
        acc_reg     = 1'b0;
        cbr_reg     = 1'b0;
    end
    // Unknown levels on an undriven pin, changing every cycle
    always @(posedge i_clk) junk <= ~junk;
    always @(negedge i_ras_n) begin
        o_ras_falls <= o_ras_falls + 1;
        acc_reg     <= 1'b0;
        cbr_reg     <= ~i_cas_n;
        row_reg     <= i_addr;
        if (!i_cas_n) begin
            int_row    <= int_row + 8'h01;
            o_int_refs <= o_int_refs + 1;
        end
    end
    always @(negedge i_cas_n) begin
        if (!i_ras_n) begin
            col_reg <= i_addr;
            acc_reg <= 1'b1;
            if (!i_we_n) begin
                mem[{row_reg, i_addr}] <= i_din;
            end
        end
    end
    // Row-only cycle: refresh from the external row, checked for sequence
    always @(posedge i_ras_n) begin
        if (!acc_reg && !cbr_reg) begin
            o_ext_refs <= o_ext_refs + 1;
            if (seen && row_reg[7:0] != exp_row) begin
                o_seq_errs <= o_seq_errs + 1;
            end
            exp_row <= row_reg[7:0] + 8'h01;
            seen    <= 1'b1;
        end
    end
    // Driven only in a read while column strobe is low
    assign o_dout = (!i_cas_n && acc_reg && i_we_n) ? mem[{row_reg, col_reg}] : junk;
endmodule
`default_nettype wire

// File: verif/dram_refresh_modes_tb_top.sv
// Self-checking bench for the DRAM controller in both refresh modes
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_modes_tb_top
    import dram_ctl_pkg::*;
;
    localparam int PWRUP_T = 20;
    localparam int REF_T   = 100;
    logic        i_clk, i_rst, i_ce, i_req_valid, i_req_write, i_req_wdata;
    logic [17:0] i_req_addr;
    logic        ready, rsp_valid, rsp_rdata, init_done, ras_n, cas_n, we_n, din, dout;
    logic        c_init_done, c_ras_n, c_cas_n, c_we_n, c_din, c_dout;
    logic [8:0]  addr, c_addr;
    logic [31:0] falls, ext, intr, seq, c_falls, c_ext, c_intr, c_seq;
    int          fail_count, compares;
    dram_ctl #(.PWRUP(PWRUP_T), .REF_INT(REF_T), .REF_MODE(REF_RAS_ONLY)) dram_ctl_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req_valid(i_req_valid),
        .i_req_write(i_req_write), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
        .o_req_ready(ready), .o_rsp_valid(rsp_valid), .o_rsp_rdata(rsp_rdata),
        .o_init_done(init_done), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n),
        .o_addr(addr), .o_din(din), .i_dout(dout));
    dram_ctl #(.PWRUP(PWRUP_T), .REF_INT(REF_T), .REF_MODE(REF_CBR)) dram_ctl_cbr_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req_valid(1'b0),
        .i_req_write(i_req_write), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
        .o_req_ready(), .o_rsp_valid(), .o_rsp_rdata(), .o_init_done(c_init_done),
        .o_ras_n(c_ras_n), .o_cas_n(c_cas_n), .o_we_n(c_we_n), .o_addr(c_addr),
        .o_din(c_din), .i_dout(c_dout));
    dram_model dram_model_i (.i_clk(i_clk), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
        .i_addr(addr), .i_din(din), .o_dout(dout), .o_ras_falls(falls), .o_ext_refs(ext),
        .o_int_refs(intr), .o_seq_errs(seq));
    dram_model dram_model_cbr_i (.i_clk(i_clk), .i_ras_n(c_ras_n), .i_cas_n(c_cas_n),
        .i_we_n(c_we_n), .i_addr(c_addr), .i_din(c_din), .o_dout(c_dout),
        .o_ras_falls(c_falls), .o_ext_refs(c_ext), .o_int_refs(c_intr), .o_seq_errs(c_seq));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic chk(input logic ge, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (ge ? !(got >= exp) : (got !== exp)) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic access(input logic wr, input logic [17:0] a, input logic wd,
                          output logic rd);
        int n;
        n = 0;
        @(posedge i_clk);
        i_req_valid <= 1'b1;
        i_req_write <= wr;
        i_req_addr  <= a;
        i_req_wdata <= wd;
        @(negedge i_clk);
        while (ready !== 1'b1 && n < 2000) begin
            @(negedge i_clk);
            n++;
        end
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        @(negedge i_clk);
        while (rsp_valid !== 1'b1 && n < 2100) begin
            @(negedge i_clk);
            n++;
        end
        chk(1'b0, 32'(n < 2100), 32'h1);
        rd = rsp_rdata;
    endtask
    task automatic t_init();
        int n;
        n = 0;
        while (init_done !== 1'b1 && n < 5000) begin
            @(negedge i_clk);
            n++;
        end
        chk(1'b1, 32'(n), 32'(PWRUP_T));
        chk(1'b1, falls, 32'h8);
        chk(1'b1, c_falls, 32'h8);
        $display("t_init finished");
    endtask
    task automatic t_rw();
        logic [17:0] a [6] = '{18'h00000, 18'h3ffff, 18'h1ff00, 18'h2aaaa, 18'h2aa55, 18'h15555};
        logic        rd;
        for (int i = 0; i < 6; i++) begin
            access(1'b1, a[i], 1'(i % 2) ^ a[i][17], rd);
            chk(1'b0, 32'(rd), 32'h0);
        end
        for (int i = 0; i < 6; i++) begin
            access(1'b0, a[i], 1'b0, rd);
            chk(1'b0, 32'(rd), 32'(1'(i % 2) ^ a[i][17]));
        end
        $display("t_rw finished");
    endtask
    task automatic t_hold();
        logic [31:0] s_falls, s_cfalls;
        logic        s_ras, s_cras;
        @(posedge i_clk);
        i_ce <= 1'b0;
        @(posedge i_clk);
        @(negedge i_clk);
        s_falls  = falls;
        s_cfalls = c_falls;
        s_ras    = ras_n;
        s_cras   = c_ras_n;
        repeat (40) @(posedge i_clk);
        @(negedge i_clk);
        chk(1'b0, 32'(ready), 32'h0);
        chk(1'b0, falls, s_falls);
        chk(1'b0, c_falls, s_cfalls);
        chk(1'b0, 32'(ras_n), 32'(s_ras));
        chk(1'b0, 32'(c_ras_n), 32'(s_cras));
        @(posedge i_clk);
        i_ce <= 1'b1;
        $display("t_hold finished");
    endtask
    task automatic t_refresh();
        logic [31:0] s_ext, s_seq, s_int, s_cint, s_cext;
        logic        rd;
        s_ext = ext;
        s_seq = seq;
        s_int = intr;
        s_cint = c_intr;
        s_cext = c_ext;
        repeat (REF_T * 260) @(posedge i_clk);
        chk(1'b1, ext - s_ext, 32'd256);
        chk(1'b0, seq, s_seq);
        chk(1'b0, intr, s_int);
        chk(1'b1, c_intr - s_cint, 32'd256);
        chk(1'b0, c_ext, s_cext);
        access(1'b0, 18'h3ffff, 1'b0, rd);
        chk(1'b0, 32'(rd), 32'h0);
        $display("t_refresh finished");
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge i_clk);
        fail_count++;
        conclude();
    end
    initial begin
        fail_count = 0;
        compares = 0;
        i_rst = 1'b1;
        i_ce = 1'b1;
        i_req_valid = 1'b0;
        i_req_write = 1'b0;
        i_req_wdata = 1'b0;
        i_req_addr = 18'h00000;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        t_init();
        t_rw();
        t_hold();
        t_refresh();
        conclude();
    end
endmodule
`default_nettype wire
